// [hw/sapc_consts.vh]
// Constants for the parallel converter control block.
// Assumes inclusion by bare name from the design files.
`ifndef SAPC_CONSTS_VH
`define SAPC_CONSTS_VH

`define SAPC_RES_BITS      12
`define SAPC_CH_BITS       2
`define SAPC_CHANNELS      4
`define SAPC_CODE_ZERO     12'h000
`define SAPC_CODE_FULL     12'hFFF
`define SAPC_SYNC_STAGES   3
`define SAPC_CNT_BITS      4

`endif

// [hw/sapc_sync.v]
// Three-stage synchroniser with agreement-based change detection.
// Assumes asynchronous input and a single mclk domain.
`timescale 1ns/1ps
module sapc_sync #(
  parameter RESET_VAL = 1'b1
) (
  mclk,
  reset,
  ce,
  din,
  dout
);
  input  wire mclk;
  input  wire reset;
  input  wire ce;
  input  wire din;
  output reg  dout;

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // First stage is only read by the second
  always @(posedge mclk) begin
    if (reset) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      dout <= RESET_VAL;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // sapc_sync

// [hw/sapc_sar.v]
// Successive-approximation register: one bit decision per step.
// Assumes comparator result is valid when step is pulsed.
`timescale 1ns/1ps
`include "sapc_consts.vh"
module sapc_sar #(
  parameter N = `SAPC_RES_BITS
) (
  mclk,
  reset,
  ce,
  start,
  step,
  cmpHigh,
  trial,
  result,
  done
);
  input  wire         mclk;
  input  wire         reset;
  input  wire         ce;
  input  wire         start;
  input  wire         step;
  input  wire         cmpHigh;
  output wire [N-1:0] trial;
  output reg  [N-1:0] result;
  output reg          done;

  reg [N-1:0] code_r;
  reg [N-1:0] mask_r;

  assign trial = code_r | mask_r;

  always @(posedge mclk) begin
    if (reset) begin
      code_r <= {N{1'b0}};
      mask_r <= {N{1'b0}};
      result <= {N{1'b0}};
      done   <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        code_r <= {N{1'b0}};
        mask_r <= {1'b1, {(N-1){1'b0}}};
      end else if (step && (mask_r != {N{1'b0}})) begin
        if (cmpHigh) begin
          code_r <= code_r | mask_r;
        end
        mask_r <= mask_r >> 1;
        if (mask_r[0]) begin
          result <= cmpHigh ? (code_r | mask_r) : code_r;
          done   <= 1'b1;
        end
      end
    end
  end
endmodule // sapc_sar

// [hw/sapc_ctrl.v]
// Top control of a 4-channel 12-bit SAR converter, parallel host port.
// Assumes host pins are asynchronous; the analog comparator decision
// arrives as cmpHigh for the trial code presented on dacCode.
`timescale 1ns/1ps
`include "sapc_consts.vh"

// Operation
// - Start on strobe fall with select low
// - Convert from next conversion clock rise
// - One bit per clock, MSB first
// - Busy low for whole conversion
// - Result valid when busy rises
// - Straight binary, MSB on first line
// - Select and read low drive result
// - Read rise with LSB high: power-down
// - Power-down drops analogEn and sampleEn only
// - Read rise with LSB low: wake
// - Decide only with select 0, busy 1
// - Four single-ended input channels
module sapc_ctrl (
  mclk,
  reset,
  ce,
  csN,
  rdN,
  wrN,
  convClk,
  channel_sel_lsb,
  channel_sel_msb,
  cmpHigh,
  busyN,
  dataOut,
  dataOe,
  channelSel,
  dacCode,
  sampleEn,
  analogEn
);
  input  wire                        mclk;
  input  wire                        reset;
  input  wire                        ce;
  input  wire                        csN;
  input  wire                        rdN;
  input  wire                        wrN;
  input  wire                        convClk;
  input  wire                        channel_sel_lsb;
  input  wire                        channel_sel_msb;
  input  wire                        cmpHigh;
  output reg                         busyN;
  output reg  [`SAPC_RES_BITS-1:0]   dataOut;
  output reg  [`SAPC_RES_BITS-1:0]   dataOe;
  output reg  [`SAPC_CH_BITS-1:0]    channelSel;
  output reg                         sampleEn;
  output reg                         analogEn;

  output wire [`SAPC_RES_BITS-1:0]   dacCode;

  // Registered trial code; dacCode shows it straight from the flop
  reg         [`SAPC_RES_BITS-1:0]   capacitive_dac;
  assign dacCode = capacitive_dac;

  localparam ST_IDLE = 2'b00;
  localparam ST_ARM  = 2'b01;
  localparam ST_CONV = 2'b10;
  localparam ST_PD   = 2'b11;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire csS;
  wire rdS;
  wire wrS;
  wire clkS;
  wire a0S;
  wire a1S;

  sapc_sync #(.RESET_VAL(1'b1)) uCs (.mclk(mclk), .reset(reset),
    .ce(ce), .din(csN), .dout(csS));
  sapc_sync #(.RESET_VAL(1'b1)) uRd (.mclk(mclk), .reset(reset),
    .ce(ce), .din(rdN), .dout(rdS));
  sapc_sync #(.RESET_VAL(1'b1)) uWr (.mclk(mclk), .reset(reset),
    .ce(ce), .din(wrN), .dout(wrS));
  sapc_sync #(.RESET_VAL(1'b0)) uClk (.mclk(mclk), .reset(reset),
    .ce(ce), .din(convClk), .dout(clkS));
  sapc_sync #(.RESET_VAL(1'b0)) uA0 (.mclk(mclk), .reset(reset),
    .ce(ce), .din(channel_sel_lsb), .dout(a0S));
  sapc_sync #(.RESET_VAL(1'b0)) uA1 (.mclk(mclk), .reset(reset),
    .ce(ce), .din(channel_sel_msb), .dout(a1S));

  // ****************************************
  // Edge detection
  // ****************************************
  reg  rdPrev_r;
  reg  wrPrev_r;
  reg  clkPrev_r;
  wire wrFall  = wrPrev_r & ~wrS;
  wire rdRise  = ~rdPrev_r & rdS;
  wire clkRise = ~clkPrev_r & clkS;

  always @(posedge mclk) begin
    if (reset) begin
      rdPrev_r  <= 1'b1;
      wrPrev_r  <= 1'b1;
      clkPrev_r <= 1'b0;
    end else if (ce) begin
      rdPrev_r  <= rdS;
      wrPrev_r  <= wrS;
      clkPrev_r <= clkS;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  reg  [1:0]                state_r;
  wire [`SAPC_RES_BITS-1:0] trial;
  wire [`SAPC_RES_BITS-1:0] result;
  wire                      sarDone;
  wire                      sarStart = (state_r == ST_ARM) && clkRise;
  wire                      sarStep  = (state_r == ST_CONV) && clkRise;

  sapc_sar #(.N(`SAPC_RES_BITS)) uSar (
    .mclk    (mclk),
    .reset   (reset),
    .ce      (ce),
    .start   (sarStart),
    .step    (sarStep),
    .cmpHigh (cmpHigh),
    .trial   (trial),
    .result  (result),
    .done    (sarDone)
  );

  // Power state only changes with conversion idle
  wire pdDecide = rdRise && !csS && busyN;

  always @(posedge mclk) begin
    if (reset) begin
      state_r        <= ST_IDLE;
      busyN          <= 1'b1;
      channelSel     <= {`SAPC_CH_BITS{1'b0}};
      dataOut        <= `SAPC_CODE_ZERO;
      capacitive_dac <= {`SAPC_RES_BITS{1'b0}};
      sampleEn       <= 1'b0;
      analogEn       <= 1'b1;
    end else if (ce) begin
      capacitive_dac <= trial;
      case (state_r)
        ST_IDLE: begin
          sampleEn <= 1'b1;
          if (wrFall && !csS) begin
            channelSel <= {a1S, a0S};
            busyN      <= 1'b0;
            state_r    <= ST_ARM;
          end else if (pdDecide && a0S) begin
            analogEn <= 1'b0;
            sampleEn <= 1'b0;
            state_r  <= ST_PD;
          end
        end
        ST_ARM: begin
          if (clkRise) begin
            sampleEn <= 1'b0;
            state_r  <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (sarDone) begin
            dataOut <= result;
            busyN   <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_PD: begin
          // Strobe ignored while powered down
          if (pdDecide && !a0S) begin
            analogEn <= 1'b1;
            state_r  <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Output bus enable
  // ****************************************
  always @(posedge mclk) begin
    if (reset) begin
      dataOe <= {`SAPC_RES_BITS{1'b0}};
    end else if (ce) begin
      dataOe <= {`SAPC_RES_BITS{~csS & ~rdS}};
    end
  end
endmodule // sapc_ctrl

// [dv/sapc_ctrl_props.sv]
// Checker for the converter control top, on its ports only.
// Assumes ce held high and host pins held for several mclk.
`timescale 1ns/1ps
module sapc_ctrl_props (
  input wire        mclk,
  input wire        reset,
  input wire        csN,
  input wire        rdN,
  input wire        wrN,
  input wire        channel_sel_lsb,
  input wire        busyN,
  input wire [11:0] dataOut,
  input wire [11:0] dataOe,
  input wire        analogEn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_start;
    $fell(wrN) && !csN && busyN && analogEn;
  endsequence
  sequence s_read;
    $fell(rdN) && !csN && analogEn;
  endsequence
  a_start_busy_low: assert property (s_start |-> ##[2:10] !busyN)
    else $error("busy did not fall after start");
  a_busy_min_low: assert property ($fell(busyN) |-> !busyN [*8])
    else $error("busy rose too early");
  a_result_held: assert property (busyN && $past(busyN)
    |-> $stable(dataOut))
    else $error("result changed while idle");
  a_read_drives_bus: assert property (s_read
    |-> ##[1:8] dataOe == 12'hFFF)
    else $error("bus not driven on read");
  a_bus_release: assert property ($rose(rdN)
    |-> ##[1:8] dataOe == 12'h000)
    else $error("bus not released");
  a_oe_all_none: assert property (dataOe == 12'h000
    || dataOe == 12'hFFF)
    else $error("partial bus drive");
  a_pd_on_lsb: assert property ($fell(analogEn) |-> channel_sel_lsb)
    else $error("power-down with address low");
  a_wake_on_lsb: assert property ($rose(analogEn)
    |-> !channel_sel_lsb)
    else $error("wake with address high");
  a_pd_idle_rd: assert property ($changed(analogEn) |-> busyN && rdN)
    else $error("power change outside idle read rise");
  a_pd_no_conv: assert property (!analogEn |-> busyN)
    else $error("converting while powered down");
endmodule // sapc_ctrl_props
bind sapc_ctrl sapc_ctrl_props u_props (
  .mclk(mclk), .reset(reset), .csN(csN), .rdN(rdN), .wrN(wrN),
  .channel_sel_lsb(channel_sel_lsb), .busyN(busyN),
  .dataOut(dataOut), .dataOe(dataOe), .analogEn(analogEn)
);

// [dv/sapc_afe_model.sv]
// Front-end stand-in: fixed level per channel, ideal comparator.
// Assumes trial code and channel settle before each bit step.
`timescale 1ns/1ps
module sapc_afe_model #(
  parameter [47:0] LEVELS = 48'h7FF_800_FFF_000
) (
  input  wire [1:0]  channelSel,
  input  wire [11:0] dacCode,
  input  wire        analogEn,
  output wire        cmpHigh
);
  // Dead when powered down, so a stray conversion reads zero
  assign cmpHigh = analogEn
    && (dacCode <= LEVELS[channelSel * 12 +: 12]);
endmodule // sapc_afe_model

// [dv/sapc_ctrl_test.sv]
// Bench: conversions on every channel, reads, power-down and wake.
// Assumes the front-end model closes the comparator loop.
`timescale 1ns/1ps
module sapc_ctrl_test;
  reg         mclk = 0;
  reg         reset = 1;
  reg         csN = 1;
  reg         rdN = 1;
  reg         wrN = 1;
  reg         convClk = 0;
  reg         lsb = 0;
  reg         msb = 0;
  wire        cmpHigh;
  wire        busyN;
  wire        analogEn;
  wire [11:0] dataOut;
  wire [11:0] dataOe;
  wire [11:0] dacCode;
  wire [1:0]  channelSel;
  wire        sampleEn;
  integer     errors = 0;
  integer     checks = 0;
  always #2 mclk = ~mclk;
  sapc_ctrl u_dut (.mclk(mclk), .reset(reset), .ce(1'b1), .csN(csN),
    .rdN(rdN), .wrN(wrN), .convClk(convClk), .channel_sel_lsb(lsb),
    .channel_sel_msb(msb), .cmpHigh(cmpHigh), .busyN(busyN),
    .dataOut(dataOut), .dataOe(dataOe), .channelSel(channelSel),
    .dacCode(dacCode), .sampleEn(sampleEn),
    .analogEn(analogEn));
  sapc_afe_model u_afe (.channelSel(channelSel), .dacCode(dacCode),
    .analogEn(analogEn), .cmpHigh(cmpHigh));
  // *****
  // Tasks
  // *****
  task check(input [11:0] seen, input [11:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  task w(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task rd_pulse;
    begin
      rdN = 0;
      w(10);
      rdN = 1;
      w(10);
    end
  endtask
  task convert(input [1:0] ch, input [11:0] exp);
    begin
      {msb, lsb} = ch;
      csN = 0;
      w(1);
      wrN = 0;
      w(4);
      wrN = 1;
      w(8);
      check(busyN, 0);
      check(sampleEn, 1);
      // Conversion clock runs only inside the frame, 320 ns period
      convClk = 1;
      w(40);
      check(sampleEn, 0);
      convClk = 0;
      w(40);
      repeat (15) begin
        convClk = 1;
        w(40);
        convClk = 0;
        w(40);
      end
      check(busyN, 1);
      check(dataOut, exp);
      check(channelSel, ch);
      lsb = 0;
      rdN = 0;
      w(10);
      check(dataOe, 12'hFFF);
      rdN = 1;
      csN = 1;
      w(10);
      check(dataOe, 12'h000);
    end
  endtask
  task power_cycle;
    begin
      csN = 0;
      lsb = 1;
      rd_pulse;
      check(analogEn, 0);
      wrN = 0;
      w(4);
      wrN = 1;
      w(20);
      check(busyN, 1);
      lsb = 0;
      rd_pulse;
      check(analogEn, 1);
      csN = 1;
      lsb = 1;
      rd_pulse;
      check(analogEn, 1);
      lsb = 0;
    end
  endtask
  task stop_test;
    begin
      if (errors == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // *****
  // Main
  // *****
  initial begin
    w(4);
    reset = 0;
    w(4);
    convert(2'h0, 12'h000);
    convert(2'h1, 12'hFFF);
    convert(2'h2, 12'h800);
    convert(2'h3, 12'h7FF);
    power_cycle;
    convert(2'h2, 12'h800);
    stop_test;
  end
  initial begin
    #60000;
    errors = errors + 1;
    stop_test;
  end
endmodule // sapc_ctrl_test
